/* src/gpcde_top.sv */
// gpio logic for ports c (pullups), d and e with peripheral pin sharing
// assumes a synchronous cpu bus on ref_clk; pins pass through pad cells outside
`timescale 1ns/1ps
`default_nettype none
module gpcde_top
	import gpcde_pkg::*;
#(
	parameter int C_W = GPCDE_C_W,
	parameter int D_W = GPCDE_D_W,
	parameter int E_W = GPCDE_E_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	// cpu register port
	input wire logic [GPCDE_AW-1:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [GPCDE_DW-1:0] bus_wdata,
	output logic [GPCDE_DW-1:0] bus_rdata,
	output logic bus_rvalid,
	// port c direction from the port c block, for pullup gating
	input wire logic [C_W-1:0] port_c_direction,
	output logic [C_W-1:0] port_c_pullup_on,
	// port d pins
	input wire logic [D_W-1:0] pd_in,
	output logic [D_W-1:0] pd_out,
	output logic [D_W-1:0] pd_oe_n,
	output logic [D_W-1:0] pd_pullup_on,
	// port e pins
	input wire logic [E_W-1:0] pe_in,
	output logic [E_W-1:0] pe_out,
	output logic [E_W-1:0] pe_oe_n,
	// spi controls and signals
	input wire logic spi_enable_bit,
	input wire logic spi_master_select_bit,
	input wire logic port_b_direction_bit0,
	input wire logic spi_sck_out,
	input wire logic spi_sck_oe,
	input wire logic spi_mosi_out,
	input wire logic spi_mosi_oe,
	input wire logic spi_miso_out,
	input wire logic spi_miso_oe,
	output logic spi_sck_in,
	output logic spi_mosi_in,
	output logic spi_miso_in,
	output logic spi_ss_in_n,
	// timer channel claims (edge/level select nonzero) and signals
	input wire logic [1:0] first_timer_module_claim,
	input wire logic [1:0] second_timer_module_claim,
	input wire logic [1:0] first_timer_module_ch_out,
	input wire logic [1:0] first_timer_module_ch_oe,
	input wire logic [1:0] second_timer_module_ch_out,
	input wire logic [1:0] second_timer_module_ch_oe,
	output logic [1:0] tim_ch_in,
	// serial interface
	input wire logic serial_iface_enable_bit,
	input wire logic serial_txd,
	output logic serial_rxd
);
	// storage
	logic [D_W-1:0] port_d_data_latch_q; // no reset
	logic [E_W-1:0] port_e_data_latch_q; // no reset
	logic [D_W-1:0] port_d_direction_q;
	logic [E_W-1:0] port_e_direction_q;
	logic [C_W-1:0] port_c_pullup_enables_q;
	logic [D_W-1:0] port_d_pullup_enables_q;
	logic [D_W-1:0] pd_sync; // synchronised pin levels
	logic [E_W-1:0] pe_sync;
	logic [C_W-1:0] pc_dir_sync; // direction comes from another block, same clock
	// shared-pin overrides
	logic [D_W-1:0] d_claim; // pin owned by a peripheral
	logic [D_W-1:0] d_per_out;
	logic [D_W-1:0] d_per_oe;
	logic [E_W-1:0] e_claim;
	logic [E_W-1:0] e_per_out;
	logic [E_W-1:0] e_per_oe;
	logic spi_ss_claim;
	logic tim_ch_claim_any;

	// address match helper, used by every register
	function automatic logic hit(input logic [GPCDE_AW-1:0] a, input logic [GPCDE_AW-1:0] ref_a);
		hit = (a == ref_a);
	endfunction

	assign pc_dir_sync = port_c_direction;

	// pin synchronisers
	gpcde_sync #(.W(D_W)) u_sync_d (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.async_in(pd_in),
		.sync_out(pd_sync)
	);
	gpcde_sync #(.W(E_W)) u_sync_e (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.async_in(pe_in),
		.sync_out(pe_sync)
	);

	// data latches: written regardless of direction, never reset
	always_ff @(posedge ref_clk) begin
		if (bus_wr && hit(bus_addr, GPCDE_ADDR_D_DATA)) begin
			port_d_data_latch_q <= bus_wdata[D_W-1:0];
		end
		if (bus_wr && hit(bus_addr, GPCDE_ADDR_E_DATA)) begin
			port_e_data_latch_q <= bus_wdata[E_W-1:0];
		end
	end

	// direction registers, cleared to inputs on reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			port_d_direction_q <= GPCDE_RST_D_DIR;
			port_e_direction_q <= GPCDE_RST_E_DIR;
		end else begin
			if (bus_wr && hit(bus_addr, GPCDE_ADDR_D_DIR)) begin
				port_d_direction_q <= bus_wdata[D_W-1:0];
			end
			if (bus_wr && hit(bus_addr, GPCDE_ADDR_E_DIR)) begin
				port_e_direction_q <= bus_wdata[E_W-1:0];
			end
		end
	end

	// pullup enables, cleared so no pullup is on after reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			port_c_pullup_enables_q <= GPCDE_RST_C_PUE;
			port_d_pullup_enables_q <= GPCDE_RST_D_PUE;
		end else begin
			if (bus_wr && hit(bus_addr, GPCDE_ADDR_C_PUE)) begin
				port_c_pullup_enables_q <= bus_wdata[C_W-1:0];
			end
			if (bus_wr && hit(bus_addr, GPCDE_ADDR_D_PUE)) begin
				port_d_pullup_enables_q <= bus_wdata[D_W-1:0];
			end
		end
	end

	// register read: data addresses mix latch and pin per direction bit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus_rdata <= '0;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= bus_rd;
			if (!bus_rd) begin
				bus_rdata <= '0;
			end else if (hit(bus_addr, GPCDE_ADDR_D_DATA)) begin
				// direction still picks source on spi/timer pins
				bus_rdata <= (port_d_direction_q & port_d_data_latch_q)
					| (~port_d_direction_q & pd_sync);
			end else if (hit(bus_addr, GPCDE_ADDR_E_DATA)) begin
				bus_rdata <= {2'h0, (port_e_direction_q & port_e_data_latch_q)
					| (~port_e_direction_q & pe_sync)};
			end else if (hit(bus_addr, GPCDE_ADDR_D_DIR)) begin
				bus_rdata <= port_d_direction_q;
			end else if (hit(bus_addr, GPCDE_ADDR_E_DIR)) begin
				bus_rdata <= {2'h0, port_e_direction_q};
			end else if (hit(bus_addr, GPCDE_ADDR_C_PUE)) begin
				bus_rdata <= {1'h0, port_c_pullup_enables_q};
			end else if (hit(bus_addr, GPCDE_ADDR_D_PUE)) begin
				bus_rdata <= port_d_pullup_enables_q;
			end else begin
				bus_rdata <= '0; // unmapped reads zero
			end
		end
	end

	// port d peripheral ownership
	always_comb begin
		d_claim = '0;
		d_per_out = '0;
		d_per_oe = '0;
		// both timers share 7:6; timer two wins where both claim
		for (int i = 0; i < 2; i++) begin
			if (second_timer_module_claim[i]) begin
				d_claim[GPCDE_D_TCH0+i] = 1'b1;
				d_per_out[GPCDE_D_TCH0+i] = second_timer_module_ch_out[i];
				d_per_oe[GPCDE_D_TCH0+i] = second_timer_module_ch_oe[i];
			end else if (first_timer_module_claim[i]) begin
				d_claim[GPCDE_D_TCH0+i] = 1'b1;
				d_per_out[GPCDE_D_TCH0+i] = first_timer_module_ch_out[i];
				d_per_oe[GPCDE_D_TCH0+i] = first_timer_module_ch_oe[i];
			end
		end
		if (spi_enable_bit) begin
			d_claim[GPCDE_D_SCK] = 1'b1;
			d_claim[GPCDE_D_MOSI] = 1'b1;
			d_claim[GPCDE_D_MISO] = 1'b1;
			d_per_out[GPCDE_D_SCK] = spi_sck_out;
			d_per_oe[GPCDE_D_SCK] = spi_sck_oe;
			d_per_out[GPCDE_D_MOSI] = spi_mosi_out;
			d_per_oe[GPCDE_D_MOSI] = spi_mosi_oe;
			d_per_out[GPCDE_D_MISO] = spi_miso_out;
			d_per_oe[GPCDE_D_MISO] = spi_miso_oe;
		end
		// slave select is input only; port b dir bit0 plays no part
		d_claim[GPCDE_D_SS] = spi_ss_claim;
	end
	assign spi_ss_claim = spi_enable_bit & ~spi_master_select_bit;
	assign tim_ch_claim_any = |(first_timer_module_claim | second_timer_module_claim);

	// port e peripheral ownership
	always_comb begin
		e_claim = '0;
		e_per_out = '0;
		e_per_oe = '0;
		if (serial_iface_enable_bit) begin
			e_claim[GPCDE_E_TXD] = 1'b1;
			e_claim[GPCDE_E_RXD] = 1'b1;
			e_per_out[GPCDE_E_TXD] = serial_txd;
			e_per_oe[GPCDE_E_TXD] = 1'b1; // transmit always drives
		end
	end

	// pin drivers: registered so outputs come from flops (one cycle late)
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pd_out <= '0;
			pd_oe_n <= '1;
			pe_out <= '0;
			pe_oe_n <= '1;
		end else begin
			// claimed pins follow the peripheral, not the direction bits
			pd_out <= (d_claim & d_per_out) | (~d_claim & port_d_data_latch_q);
			pd_oe_n <= ~((d_claim & d_per_oe) | (~d_claim & port_d_direction_q));
			pe_out <= (e_claim & e_per_out) | (~e_claim & port_e_data_latch_q);
			pe_oe_n <= ~((e_claim & e_per_oe) | (~e_claim & port_e_direction_q));
		end
	end

	// pullups: enabled bit and input direction only
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			port_c_pullup_on <= '0;
			pd_pullup_on <= '0;
		end else begin
			port_c_pullup_on <= port_c_pullup_enables_q & ~pc_dir_sync;
			pd_pullup_on <= port_d_pullup_enables_q & ~port_d_direction_q;
		end
	end

	// peripheral inputs from synchronised pins; idle values when not claimed, timer inputs idle only when no channel is claimed
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			spi_sck_in <= 1'b0;
			spi_mosi_in <= 1'b0;
			spi_miso_in <= 1'b0;
			spi_ss_in_n <= 1'b1;
			tim_ch_in <= '0;
			serial_rxd <= 1'b1;
		end else begin
			spi_sck_in <= spi_enable_bit & pd_sync[GPCDE_D_SCK];
			spi_mosi_in <= spi_enable_bit & pd_sync[GPCDE_D_MOSI];
			spi_miso_in <= spi_enable_bit & pd_sync[GPCDE_D_MISO];
			spi_ss_in_n <= spi_ss_claim ? pd_sync[GPCDE_D_SS] : 1'b1;
			tim_ch_in <= tim_ch_claim_any ? pd_sync[GPCDE_D_TCH1:GPCDE_D_TCH0] : 2'h0;
			serial_rxd <= serial_iface_enable_bit ? pe_sync[GPCDE_E_RXD] : 1'b1;
		end
	end
endmodule
`default_nettype wire

/* src/gpcde_pkg.sv */
// package for the port c/d/e gpio block: register addresses, widths, pin indices
// assumes an 8-bit cpu data bus with 16-bit addresses
package gpcde_pkg;
	// widths
	localparam int GPCDE_AW = 16;
	localparam int GPCDE_DW = 8;
	localparam int GPCDE_C_W = 7;
	localparam int GPCDE_D_W = 8;
	localparam int GPCDE_E_W = 6;
	// register addresses (data addresses as printed, others chosen locally)
	localparam logic [15:0] GPCDE_ADDR_D_DATA = 16'h0003;
	localparam logic [15:0] GPCDE_ADDR_E_DATA = 16'h0008;
	localparam logic [15:0] GPCDE_ADDR_D_DIR = 16'h0007;
	localparam logic [15:0] GPCDE_ADDR_E_DIR = 16'h000C;
	localparam logic [15:0] GPCDE_ADDR_C_PUE = 16'h004C;
	localparam logic [15:0] GPCDE_ADDR_D_PUE = 16'h004D;
	// reset values
	localparam logic [7:0] GPCDE_RST_D_DIR = 8'h00;
	localparam logic [5:0] GPCDE_RST_E_DIR = 6'h00;
	localparam logic [6:0] GPCDE_RST_C_PUE = 7'h00;
	localparam logic [7:0] GPCDE_RST_D_PUE = 8'h00;
	// port d shared pin positions
	localparam int GPCDE_D_SS = 0;
	localparam int GPCDE_D_MISO = 1;
	localparam int GPCDE_D_MOSI = 2;
	localparam int GPCDE_D_SCK = 3;
	localparam int GPCDE_D_TCH0 = 6;
	localparam int GPCDE_D_TCH1 = 7;
	// port e shared pin positions
	localparam int GPCDE_E_TXD = 0;
	localparam int GPCDE_E_RXD = 1;
endpackage

/* src/gpcde_sync.sv */
// two-flop synchroniser for a vector of pin levels
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module gpcde_sync #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q; // first stage, read only by second stage
	// both stages clear on reset; values only ever come from the pin
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* test/gpcde_pins.sv */
// pin-side model: outside drivers, pullups and floating lines
// assumes active-low output enables from gpcde_top
`timescale 1ns/1ps
`default_nettype none
module gpcde_pins (
	input wire logic [7:0] pd_out,
	input wire logic [7:0] pd_oe_n,
	input wire logic [7:0] pd_pullup_on,
	input wire logic [5:0] pe_out,
	input wire logic [5:0] pe_oe_n,
	input wire logic [7:0] ext_d,
	input wire logic [7:0] ext_dz,
	input wire logic [5:0] ext_e,
	output logic [7:0] pd_in,
	output logic [5:0] pe_in
);
	// pad drive wins, then outside driver, then pullup; a float shows the inverse so it never reads as luck
	assign pd_in = (~pd_oe_n & pd_out) | (pd_oe_n & ~ext_dz & ext_d) | (pd_oe_n & ext_dz & (pd_pullup_on | ~ext_d));
	// port e has no pullups, outside always drives
	assign pe_in = (~pe_oe_n & pe_out) | (pe_oe_n & ext_e);
endmodule
`default_nettype wire

/* test/gpcde_top_assertions.sv */
// checker for gpcde_top port relations
// assumes one clock domain, bound onto gpcde_top
`timescale 1ns/1ps
`default_nettype none
module gpcde_top_chk
	import gpcde_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [15:0] bus_addr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rvalid,
	input wire logic [6:0] port_c_direction,
	input wire logic [6:0] port_c_pullup_on,
	input wire logic [7:0] pd_oe_n,
	input wire logic [7:0] pd_pullup_on,
	input wire logic [5:0] pe_out,
	input wire logic [5:0] pe_oe_n,
	input wire logic spi_enable_bit,
	input wire logic spi_master_select_bit,
	input wire logic spi_sck_in,
	input wire logic spi_mosi_in,
	input wire logic spi_miso_in,
	input wire logic spi_ss_in_n,
	input wire logic [1:0] first_timer_module_claim,
	input wire logic [1:0] second_timer_module_claim,
	input wire logic [1:0] tim_ch_in,
	input wire logic serial_iface_enable_bit,
	input wire logic serial_txd,
	input wire logic serial_rxd
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// address hits one of the six registers
	logic mapped;
	assign mapped = bus_addr inside {GPCDE_ADDR_D_DATA, GPCDE_ADDR_E_DATA, GPCDE_ADDR_D_DIR,
		GPCDE_ADDR_E_DIR, GPCDE_ADDR_C_PUE, GPCDE_ADDR_D_PUE};
	a_read_valid: assert property (bus_rd |=> bus_rvalid)
		else $error("no read answer");
	// unmapped reads answer zero
	a_unmapped_zero: assert property (bus_rd && !mapped |=> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_c_pullup_gate: assert property ((port_c_pullup_on & $past(port_c_direction)) == 7'h00)
		else $error("port c pullup on output pin");
	a_d_pullup_gate: assert property ((pd_pullup_on[5:4] & ~pd_oe_n[5:4]) == 2'h0)
		else $error("port d pullup on driven pin");
	a_ss_idle: assert property (!spi_enable_bit || spi_master_select_bit |=> spi_ss_in_n)
		else $error("select active while not slave");
	a_spi_in_off: assert property (!spi_enable_bit |=> !(spi_sck_in | spi_mosi_in | spi_miso_in))
		else $error("spi input live while disabled");
	a_rxd_idle: assert property (!serial_iface_enable_bit |=> serial_rxd)
		else $error("rxd not idle while disabled");
	a_txd_drive: assert property (serial_iface_enable_bit ##1 serial_iface_enable_bit |->
		!pe_oe_n[0] && pe_out[0] == $past(serial_txd)) else $error("txd pin not driven");
	a_tim_idle: assert property ((first_timer_module_claim | second_timer_module_claim) == 2'h0 |=> tim_ch_in == 2'h0)
		else $error("timer input live unclaimed");
endmodule
bind gpcde_top gpcde_top_chk gpcde_top_chk_i (.*);
`default_nettype wire

/* test/tb.sv */
// self-checking bench for gpcde_top, one task per scenario
// assumes gpcde_pins stands for the board
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb;
	import gpcde_pkg::*;
	logic ref_clk = 1'h0, rstn = 1'h0, bus_wr = 1'h0, bus_rd = 1'h0, bus_rvalid;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00, bus_rdata, pd_out, pd_oe_n, pd_pullup_on, pd_in, ext_d = 8'h00, ext_dz = 8'h00;
	logic [6:0] port_c_direction = 7'h00, port_c_pullup_on;
	logic [5:0] pe_out, pe_oe_n, pe_in, ext_e = 6'h00;
	logic spi_sck_in, spi_mosi_in, spi_miso_in, spi_ss_in_n, serial_rxd;
	logic spi_enable_bit = 1'h0, spi_master_select_bit = 1'h0, port_b_direction_bit0 = 1'h0, serial_txd = 1'h0;
	logic spi_sck_out = 1'h0, spi_sck_oe = 1'h0, spi_mosi_out = 1'h0, spi_mosi_oe = 1'h0, spi_miso_out = 1'h0;
	logic spi_miso_oe = 1'h0, serial_iface_enable_bit = 1'h0;
	logic [1:0] first_timer_module_claim = 2'h0, second_timer_module_claim = 2'h0, first_timer_module_ch_out = 2'h0, first_timer_module_ch_oe = 2'h0;
	logic [1:0] second_timer_module_ch_out = 2'h0, second_timer_module_ch_oe = 2'h0, tim_ch_in;
	int num_errors = 0, checks_done = 0, cyc = 0;
	always #50 ref_clk = ~ref_clk;
	gpcde_top gpcde_top_i (.*);
	gpcde_pins gpcde_pins_i (.*);
	// hang guard, scenarios need about 140 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one write strobe, inputs move on falling edges only
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'h1;
		@(negedge ref_clk);
		bus_wr = 1'h0;
	endtask
	// read answer stands for the one cycle after the taking edge, so look at the next falling edge
	task rd(input string n, input logic [15:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		bus_addr = a;
		bus_rd = 1'h1;
		@(negedge ref_clk);
		bus_rd = 1'h0;
		`CHK("rvalid", 1'h1, bus_rvalid)
		`CHK(n, e, bus_rdata)
	endtask
	// covers register to pin, two sync flops and the registered peripheral input
	task settle;
		repeat (4) @(negedge ref_clk);
	endtask
	task rst;
		@(negedge ref_clk);
		rstn = 1'h0;
		repeat (16) @(negedge ref_clk);
		rstn = 1'h1;
	endtask
	task t_dport;
		ext_d = 8'h3C;
		wr(GPCDE_ADDR_D_DATA, 8'hA5);
		wr(GPCDE_ADDR_D_DIR, 8'h0F);
		settle;
		`CHK("pd_oe_n", 8'hF0, pd_oe_n)
		`CHK("pd_out", 4'h5, pd_out[3:0])
		rd("d mixed", GPCDE_ADDR_D_DATA, 8'h35);
		wr(GPCDE_ADDR_D_DATA, 8'h5A);
		rd("d after write", GPCDE_ADDR_D_DATA, 8'h3A);
		rd("d dir", GPCDE_ADDR_D_DIR, 8'h0F);
		rd("unmapped", 16'h0005, 8'h00);
		$display("t_dport end");
	endtask
	task t_eport;
		ext_e = 6'h33;
		wr(GPCDE_ADDR_E_DATA, 8'h15);
		wr(GPCDE_ADDR_E_DIR, 8'h2A);
		settle;
		`CHK("pe_oe_n", 6'h15, pe_oe_n)
		rd("e mixed", GPCDE_ADDR_E_DATA, 8'h11);
		wr(GPCDE_ADDR_E_DIR, 8'hFF);
		rd("e dir", GPCDE_ADDR_E_DIR, 8'h3F);
		rd("e latch", GPCDE_ADDR_E_DATA, 8'h15);
		$display("t_eport end");
	endtask
	task t_pull;
		wr(GPCDE_ADDR_D_DIR, 8'h00);
		ext_dz = 8'hFF;
		ext_d = 8'hF0;
		wr(GPCDE_ADDR_D_PUE, 8'h33);
		settle;
		`CHK("pd_pullup_on", 8'h33, pd_pullup_on)
		rd("d pulled", GPCDE_ADDR_D_DATA, 8'h3F);
		wr(GPCDE_ADDR_D_DIR, 8'h01);
		settle;
		`CHK("pd_pullup_on out", 8'h32, pd_pullup_on)
		port_c_direction = 7'h0F;
		wr(GPCDE_ADDR_C_PUE, 8'h7F);
		settle;
		`CHK("port_c_pullup_on", 7'h70, port_c_pullup_on)
		rd("c pue", GPCDE_ADDR_C_PUE, 8'h7F);
		ext_dz = 8'h00;
		$display("t_pull end");
	endtask
	task t_reset;
		rst;
		`CHK("pd_oe_n rst", 8'hFF, pd_oe_n)
		rd("d pue rst", GPCDE_ADDR_D_PUE, 8'h00);
		rd("c pue rst", GPCDE_ADDR_C_PUE, 8'h00);
		rd("e dir rst", GPCDE_ADDR_E_DIR, 8'h00);
		wr(GPCDE_ADDR_D_DIR, 8'hFF);
		rd("d kept", GPCDE_ADDR_D_DATA, 8'h5A);
		wr(GPCDE_ADDR_E_DIR, 8'hFF);
		rd("e kept", GPCDE_ADDR_E_DATA, 8'h15);
		$display("t_reset end");
	endtask
	task t_spi;
		wr(GPCDE_ADDR_D_DIR, 8'h0E);
		ext_d = 8'h02;
		spi_enable_bit = 1'h1;
		spi_master_select_bit = 1'h1;
		port_b_direction_bit0 = 1'h1;
		spi_sck_oe = 1'h1;
		spi_sck_out = 1'h1;
		spi_mosi_oe = 1'h1;
		settle;
		`CHK("spi oe_n", 3'h1, pd_oe_n[3:1])
		`CHK("spi out", 2'h2, pd_out[3:2])
		`CHK("miso in", 1'h1, spi_miso_in)
		`CHK("sck in", 1'h1, spi_sck_in)
		`CHK("mosi in", 1'h0, spi_mosi_in)
		`CHK("ss master", 1'h1, spi_ss_in_n)
		rd("d spi", GPCDE_ADDR_D_DATA, 8'h0A);
		spi_master_select_bit = 1'h0;
		settle;
		`CHK("ss slave", 1'h0, spi_ss_in_n)
		spi_enable_bit = 1'h0;
		settle;
		`CHK("gpio back", 8'hF1, pd_oe_n)
		`CHK("sck in off", 1'h0, spi_sck_in)
		$display("t_spi end");
	endtask
	task t_tim_sci;
		wr(GPCDE_ADDR_D_DIR, 8'h00);
		ext_d = 8'h40;
		second_timer_module_claim = 2'h3;
		second_timer_module_ch_oe = 2'h2;
		second_timer_module_ch_out = 2'h2;
		first_timer_module_claim = 2'h1;
		first_timer_module_ch_oe = 2'h1;
		settle;
		`CHK("second_timer_module oe_n", 2'h1, pd_oe_n[7:6])
		`CHK("second_timer_module out", 1'h1, pd_out[7])
		`CHK("tim in", 2'h3, tim_ch_in)
		second_timer_module_claim = 2'h0;
		settle;
		`CHK("first_timer_module oe_n", 2'h2, pd_oe_n[7:6])
		ext_e = 6'h00;
		serial_iface_enable_bit = 1'h1;
		serial_txd = 1'h1;
		settle;
		`CHK("sci oe_n", 2'h2, pe_oe_n[1:0])
		`CHK("txd", 1'h1, pe_out[0])
		`CHK("rxd", 1'h0, serial_rxd)
		serial_iface_enable_bit = 1'h0;
		settle;
		`CHK("rxd idle", 1'h1, serial_rxd)
		`CHK("e gpio", 6'h00, pe_oe_n)
		$display("t_tim_sci end");
	endtask
	initial begin
		rst;
		t_dport;
		t_eport;
		t_pull;
		t_reset;
		t_spi;
		t_tim_sci;
		tally_and_finish;
	end
endmodule
`default_nettype wire
